// [core/oms_mode_ctrl.sv]
/*
 * oms_mode_ctrl: operating-mode capture, protection, debug entry and
 * the multiplexed external bus on two 8-bit ports.
 * assumes: pins synchronous to clk_i; ports resolved outside from the
 * enables; mode writes and debug commands come as one-cycle strobes.
 */
// Functional notes
// - capture three pins when reset ends
// - pin triplet picks one of modes
// - reserved triplet becomes peripheral mode
// - mode bits readable, changes restricted
// - seven modes, each with bus setup
// - normal modes protect, special modes relax
// - single-chip: ports are general I/O
// - wide: both ports carry address/data
// - narrow: address on both, data first port
// - narrow word: high byte then low
// - second byte uses address plus one
// - special single-chip starts with debug active
// - normal: debug enabled, then activated
// - peripheral: core idle, external master rules
// - peripheral mode changes only through reset
// - special bit writable while 0, first ignored
// - select bits write limits, no peripheral
`default_nettype none
module oms_mode_ctrl
    import oms_pkg::*;
(
    input  wire logic        clk_i,            // system clock
    input  wire logic        rst_i,            // async reset, high
    input  wire logic        ce_i,             // clock enable
    input  wire logic        background_pin_i, // mode strap
    input  wire logic        mode_pin_b_i,     // mode strap b
    input  wire logic        mode_pin_a_i,     // mode strap a
    input  wire logic        mode_wr_i,        // mode write strobe
    input  wire oms_mode_t   mode_wr_data_i,   // mode write value
    input  wire logic        dbg_enable_i,     // debug enable command
    input  wire logic        dbg_activate_i,   // debug activate command
    input  wire logic        dbg_exit_i,       // leave active debug
    input  wire logic        req_i,            // bus transfer request
    input  wire logic        req_we_i,         // 1 = write
    input  wire logic        req_word_i,       // 1 = 16-bit
    input  wire logic [15:0] req_addr_i,       // transfer address
    input  wire logic [15:0] req_wdata_i,      // transfer write data
    input  wire logic [7:0]  gpio_a_i,         // first port I/O data
    input  wire logic [7:0]  gpio_a_dir_i,     // first port I/O dir
    input  wire logic [7:0]  gpio_b_i,         // second port I/O data
    input  wire logic [7:0]  gpio_b_dir_i,     // second port I/O dir
    input  wire logic [7:0]  port_a_i,         // first port pin level
    input  wire logic [7:0]  port_b_i,         // second port pin level
    output logic             mode_valid_o,     // pins captured
    output oms_mode_t        mode_o,           // current mode bits
    output oms_flags_t       flags_o,          // decoded mode
    output logic             dbg_en_o,         // debug enabled
    output logic             dbg_act_o,        // debug active
    output logic             busy_o,           // transfer running
    output logic             done_o,           // transfer done pulse
    output logic [15:0]      rdata_o,          // read data
    output logic [7:0]       port_a_o,         // first port out
    output logic [7:0]       port_a_oe_o,      // first port enable
    output logic [7:0]       port_b_o,         // second port out
    output logic [7:0]       port_b_oe_o       // second port enable
);

    // ========================================================
    // state
    // ========================================================
    oms_state_t st;          // all registered state
    oms_state_t next_st;     // next value
    oms_mode_t  pins_now;    // strap levels
    oms_mode_t  gate_mode;   // mode after write filter
    logic       gate_first;  // first-write flag after filter
    logic       gate_once;   // once flag after filter

    assign pins_now = oms_mode_t'({background_pin_i, mode_pin_b_i,
                                   mode_pin_a_i});

    // write filter, only live once the pins are held
    oms_mode_wrgate u_wrgate (
        .mode_i       (st.mode),
        .first_done_i (st.first_done),
        .once_done_i  (st.once_done),
        .wr_i         (mode_wr_i && st.captured),
        .wdata_i      (mode_wr_data_i),
        .mode_o       (gate_mode),
        .first_done_o (gate_first),
        .once_done_o  (gate_once)
    );

    // ========================================================
    // next state
    // ========================================================
    always_comb begin
        next_st      = st;
        next_st.done = 1'b0;
        if (!st.captured) begin
            // first enabled edge after release takes the straps;
            // a flop under async reset may only load a constant
            next_st.captured   = 1'b1;
            next_st.mode       = oms_force(pins_now);
            next_st.first_done = 1'b0;
            next_st.once_done  = 1'b0;
            next_st.dbg_en     = (next_st.mode == OMS_MODE_SSC);
            next_st.dbg_act    = (next_st.mode == OMS_MODE_SSC);
        end else begin
            next_st.mode       = gate_mode;
            next_st.first_done = gate_first;
            next_st.once_done  = gate_once;
            // debug: refused in peripheral mode to avoid bus fights
            if (!st.flags.periph) begin
                if (dbg_enable_i)
                    next_st.dbg_en = 1'b1;
                if (dbg_exit_i)
                    next_st.dbg_act = 1'b0;
                // activation needs a prior enable; set wins over exit
                if (dbg_activate_i && st.dbg_en)
                    next_st.dbg_act = 1'b1;
            end
            // external bus sequencer
            case (st.bst)
                OMS_IDLE: begin
                    // requests only in expanded modes
                    if (req_i && st.flags.expanded) begin
                        next_st.bst    = OMS_ADDR;
                        next_st.addr   = req_addr_i;
                        next_st.wdata  = req_wdata_i;
                        next_st.we     = req_we_i;
                        next_st.word   = req_word_i;
                        next_st.second = 1'b0;
                    end
                end
                OMS_ADDR: begin
                    next_st.bst = OMS_DATA;
                end
                OMS_DATA: begin
                    if (st.flags.narrow) begin
                        // byte lanes on the first port only
                        if (!st.we) begin
                            if (st.word && !st.second)
                                next_st.rdata[15:8] = port_a_i;
                            else if (st.word)
                                next_st.rdata[7:0] = port_a_i;
                            else
                                next_st.rdata = {8'h00, port_a_i};
                        end
                        if (st.word && !st.second) begin
                            // low byte follows at the next address
                            next_st.second = 1'b1;
                            next_st.addr   =
                                16'(st.addr + OMS_ADDR_STEP);
                            next_st.bst    = OMS_ADDR;
                        end else begin
                            next_st.bst  = OMS_IDLE;
                            next_st.done = 1'b1;
                        end
                    end else begin
                        if (!st.we)
                            next_st.rdata = {port_a_i, port_b_i};
                        next_st.bst  = OMS_IDLE;
                        next_st.done = 1'b1;
                    end
                end
                default: begin
                    next_st.bst = OMS_IDLE;
                end
            endcase
        end
        next_st.flags = oms_decode(next_st.mode);
        next_st.busy  = (next_st.bst != OMS_IDLE);
        // port drive, registered so the pins never glitch
        next_st.pa    = 8'h00;
        next_st.pb    = 8'h00;
        next_st.pa_oe = OMS_OE_NONE;
        next_st.pb_oe = OMS_OE_NONE;
        if (!next_st.captured) begin
            // nothing driven before the mode is known
        end else if (next_st.flags.single) begin
            next_st.pa    = gpio_a_i;
            next_st.pa_oe = gpio_a_dir_i;
            next_st.pb    = gpio_b_i;
            next_st.pb_oe = gpio_b_dir_i;
        end else if (next_st.flags.periph) begin
            // external master owns the ports; stay off them
        end else if (next_st.bst == OMS_ADDR) begin
            next_st.pa    = next_st.addr[15:8];
            next_st.pb    = next_st.addr[7:0];
            next_st.pa_oe = OMS_OE_ALL;
            next_st.pb_oe = OMS_OE_ALL;
        end else if (next_st.bst == OMS_DATA) begin
            next_st.pa_oe = next_st.we ? OMS_OE_ALL : OMS_OE_NONE;
            if (next_st.flags.narrow) begin
                // second port keeps the low address byte
                next_st.pb    = next_st.addr[7:0];
                next_st.pb_oe = OMS_OE_ALL;
                next_st.pa    = (next_st.word && !next_st.second)
                              ? next_st.wdata[15:8]
                              : next_st.wdata[7:0];
            end else begin
                next_st.pa    = next_st.wdata[15:8];
                next_st.pb    = next_st.wdata[7:0];
                next_st.pb_oe = next_st.pa_oe;
            end
        end
    end

    // ========================================================
    // registers
    // ========================================================
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i)
            st <= OMS_RST_STATE;
        else if (ce_i)
            st <= next_st;
    end

    // outputs, straight from the state flops
    assign mode_valid_o = st.captured;
    assign mode_o       = st.mode;
    assign flags_o      = st.flags;
    assign dbg_en_o     = st.dbg_en;
    assign dbg_act_o    = st.dbg_act;
    assign busy_o       = st.busy;
    assign done_o       = st.done;
    assign rdata_o      = st.rdata;
    assign port_a_o     = st.pa;
    assign port_a_oe_o  = st.pa_oe;
    assign port_b_o     = st.pb;
    assign port_b_oe_o  = st.pb_oe;

    // ========================================================
    // checks
    // ========================================================
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_strap_capture: assert property (
        (!st.captured && ce_i) |=>
            st.captured && st.mode == oms_force($past(pins_now)))
        else $error("mode not taken from straps");

    a_no_reserved: assert property (
        st.captured |-> !(st.mode.special_mode_n &&
            {st.mode.mode_pin_b, st.mode.mode_pin_a} == OMS_SEL_PERIPH))
        else $error("reserved mode stored");

    a_periph_locked: assert property (
        (st.captured && ce_i) |=> st.flags.periph == $past(st.flags.periph))
        else $error("peripheral mode changed without reset");

    a_normal_stays: assert property (
        (st.captured && st.mode.special_mode_n) |=> st.mode.special_mode_n)
        else $error("normal mode left by write");

    a_first_ignored: assert property (
        (st.captured && ce_i && mode_wr_i && !st.first_done &&
         !st.mode.special_mode_n) |=> st.mode == $past(st.mode))
        else $error("first special write took effect");

    a_single_no_bus: assert property (
        // a mode write may leave single-chip on that same edge
        (st.flags.single && st.captured && ce_i) |=>
            st.bst == OMS_IDLE && (!st.flags.single ||
                                   st.pa_oe == $past(gpio_a_dir_i)))
        else $error("bus cycle in single-chip mode");

    a_second_addr: assert property (
        $rose(st.second) |-> st.addr == 16'($past(st.addr) + OMS_ADDR_STEP)
            && st.bst == OMS_ADDR && {st.pa, st.pb} == st.addr)
        else $error("second byte address not incremented");

    a_high_first: assert property (
        (st.bst == OMS_DATA && st.flags.narrow && st.we && st.word &&
         !st.second) |-> st.pa == st.wdata[15:8] ##2 st.pa == st.wdata[7:0])
        else $error("narrow bytes out of order");

    a_wide_data: assert property (
        (st.bst == OMS_DATA && st.flags.wide && st.we) |->
            {st.pa, st.pb} == st.wdata && st.pb_oe == OMS_OE_ALL)
        else $error("wide write data not on ports");

    a_narrow_addr: assert property (
        (st.bst == OMS_DATA && st.flags.narrow) |->
            st.pb == st.addr[7:0] && st.pb_oe == OMS_OE_ALL)
        else $error("narrow address lost on second port");

    a_debug_order: assert property (
        ($rose(st.dbg_act) && $past(st.captured)) |-> $past(st.dbg_en))
        else $error("debug active without enable");

    a_ssc_debug: assert property (
        $rose(st.captured) |-> st.dbg_act == (st.mode == OMS_MODE_SSC))
        else $error("debug state wrong at reset end");

    a_periph_quiet: assert property (
        st.flags.periph |-> st.bst == OMS_IDLE && st.pa_oe == OMS_OE_NONE
            && st.pb_oe == OMS_OE_NONE && !st.dbg_act)
        else $error("device active in peripheral mode");

    a_flag_decode: assert property (
        st.captured |-> (st.flags.expanded == (st.flags.wide ||
            st.flags.narrow)) && (st.flags.special != st.mode.special_mode_n))
        else $error("mode flags inconsistent");

    c_narrow_word: cover property ($rose(st.second) ##2 st.done);
    c_wide_read:   cover property (st.flags.wide && st.done && !st.we);
    c_mode_write:  cover property (st.captured && ce_i && mode_wr_i
                                   ##1 st.mode != $past(st.mode));
    c_debug_on:    cover property (!st.flags.special && $rose(st.dbg_act));

endmodule
`default_nettype wire

// [core/oms_mode_wrgate.sv]
/*
 * oms_mode_wrgate: decides which part of a run-time mode write is kept.
 * assumes: caller only asserts wr_i after the pins were captured.
 */
`default_nettype none
module oms_mode_wrgate
    import oms_pkg::*;
(
    input  wire oms_mode_t mode_i,       // stored mode
    input  wire logic      first_done_i, // a write was seen
    input  wire logic      once_done_i,  // one-time write used
    input  wire logic      wr_i,         // write strobe
    input  wire oms_mode_t wdata_i,      // written value
    output oms_mode_t      mode_o,       // resulting mode
    output logic           first_done_o, // updated first flag
    output logic           once_done_o   // updated once flag
);

    // ========================================================
    // write qualification
    // ========================================================
    // a select of peripheral or reserved leaves the select bits; in special mode the special bit still takes the write
    always_comb begin
        logic       sel_bad;
        oms_flags_t cur_fl;
        sel_bad      = ({wdata_i.mode_pin_b, wdata_i.mode_pin_a}
                        == OMS_SEL_PERIPH);
        // decoded stored mode, kept local so no field of a call is read
        cur_fl       = oms_decode(mode_i);
        mode_o       = mode_i;
        first_done_o = first_done_i;
        once_done_o  = once_done_i;
        if (wr_i && !cur_fl.periph) begin
            first_done_o = 1'b1;
            if (!mode_i.special_mode_n) begin
                // special: everything but the first write counts
                if (first_done_i) begin
                    mode_o.special_mode_n = wdata_i.special_mode_n;
                    if (!sel_bad) begin
                        mode_o.mode_pin_b = wdata_i.mode_pin_b;
                        mode_o.mode_pin_a = wdata_i.mode_pin_a;
                    end
                end
            end else begin
                // normal: special bit locked, selects writable once
                once_done_o = 1'b1;
                if (!once_done_i && !sel_bad) begin
                    mode_o.mode_pin_b = wdata_i.mode_pin_b;
                    mode_o.mode_pin_a = wdata_i.mode_pin_a;
                end
            end
        end
    end

endmodule
`default_nettype wire

// [pkg/oms_pkg.sv]
/*
 * oms_pkg: shared types, constants and helpers of the operating-mode
 * select block (mode capture, mode protection, debug entry, bus ports).
 * assumes: one clock, asynchronous active-high reset, no software bus.
 */
`default_nettype none
package oms_pkg;

    // ========================================================
    // widths and constants
    // ========================================================
    localparam int          OMS_PORT_W     = 8;      // width of each port
    localparam int          OMS_ADDR_W     = 16;     // external address
    localparam logic [15:0] OMS_ADDR_STEP  = 16'h0001; // second byte step
    localparam logic [7:0]  OMS_OE_ALL     = 8'hff;  // whole port driven
    localparam logic [7:0]  OMS_OE_NONE    = 8'h00;  // whole port released
    localparam logic [1:0]  OMS_SEL_PERIPH = 2'h2;   // mode pins b,a = 10

    // ========================================================
    // carriers
    // ========================================================
    typedef struct packed {
        logic special_mode_n;   // 1 = normal, 0 = special
        logic mode_pin_b;       // captured / stored select b
        logic mode_pin_a;       // captured / stored select a
    } oms_mode_t;

    typedef struct packed {
        logic single;           // no external bus
        logic expanded;         // multiplexed bus present
        logic wide;             // 16-bit data on both ports
        logic narrow;           // 8-bit data on first port
        logic special;          // protection relaxed
        logic periph;           // core held, external master
    } oms_flags_t;

    typedef enum logic [1:0] {
        OMS_IDLE = 2'b00,       // no external cycle
        OMS_ADDR = 2'b01,       // address phase
        OMS_DATA = 2'b10        // data phase
    } oms_bus_st_t;

    typedef struct packed {
        logic        captured;   // pins taken after reset release
        logic        first_done; // a mode write has been seen
        logic        once_done;  // normal-mode one-time write used
        oms_mode_t   mode;       // stored mode bits
        oms_flags_t  flags;      // decoded mode
        logic        dbg_en;     // debug enabled
        logic        dbg_act;    // debug active
        oms_bus_st_t bst;        // external cycle phase
        logic        busy;       // transfer in progress
        logic        second;     // second byte of narrow word
        logic        word;       // 16-bit transfer
        logic        we;         // write transfer
        logic [15:0] addr;       // current address
        logic [15:0] wdata;      // write data
        logic [15:0] rdata;      // read data
        logic        done;       // transfer finished pulse
        logic [7:0]  pa;         // first port out
        logic [7:0]  pa_oe;      // first port enable
        logic [7:0]  pb;         // second port out
        logic [7:0]  pb_oe;      // second port enable
    } oms_state_t;

    localparam oms_mode_t  OMS_MODE_SSC   = oms_mode_t'(3'h0);
    localparam oms_state_t OMS_RST_STATE  = '0;

    // ========================================================
    // helpers
    // ========================================================
    // reserved combination turns into peripheral mode
    function automatic oms_mode_t oms_force(input oms_mode_t m);
        oms_mode_t r;
        r = m;
        if (m.special_mode_n && {m.mode_pin_b, m.mode_pin_a} == OMS_SEL_PERIPH)
            r = oms_mode_t'({1'b0, OMS_SEL_PERIPH});
        return r;
    endfunction

    // stored mode bits into per-use flags
    function automatic oms_flags_t oms_decode(input oms_mode_t m);
        oms_flags_t f;
        logic [1:0] sel;
        sel        = {m.mode_pin_b, m.mode_pin_a};
        f.special  = !m.special_mode_n;
        f.periph   = (sel == OMS_SEL_PERIPH);
        f.single   = (sel == 2'h0);
        f.wide     = (sel == 2'h3);
        f.narrow   = (sel == 2'h1);
        f.expanded = f.wide || f.narrow;
        return f;
    endfunction

endpackage
`default_nettype wire

// [test/oms_bus_model.sv]
/* oms_bus_model: external memory on the two multiplexed ports.
   assumes: address phase drives both ports; a read releases port a. */
`default_nettype none
module oms_bus_model (
    input  wire logic [7:0] a_i,    // first port out
    input  wire logic [7:0] a_oe_i, // first port enable
    input  wire logic [7:0] b_i,    // second port out
    input  wire logic [7:0] b_oe_i, // second port enable
    input  wire logic       clk_i,  // system clock
    output var  logic [7:0] a_o,    // first port pin level
    output var  logic [7:0] b_o     // second port pin level
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] addr;          // last cycle with both ports driven
    logic        ph = 1'b0;     // previous cycle drove both ports
    logic [7:0]  la = 8'h00;    // last level, first port
    logic [7:0]  lb = 8'h00;    // last level, second port
    logic [7:0]  ma;            // model drive, first port
    logic [7:0]  mb;            // model drive, second port
    // =============================================================
    // address latch: taken whenever both ports are driven, write data phases included
    // =============================================================
    always_ff @(posedge clk_i) begin
        ph <= &{a_oe_i, b_oe_i};
        if (&{a_oe_i, b_oe_i})
            addr <= {a_i, b_i};
        la <= a_o;
        lb <= b_o;
    end
    // byte at x reads x lo ^ 3c in the cycle after both ports were driven,
    // else garbage so a stale value can never pass for read data
    always_comb begin
        ma  = ph ? addr[7:0] ^ 8'h3c : ~la;
        mb  = ph ? (addr[7:0] + 8'h01) ^ 8'h3c : ~lb;
        a_o = (a_i & a_oe_i) | (ma & ~a_oe_i);
        b_o = (b_i & b_oe_i) | (mb & ~b_oe_i);
    end
endmodule
`default_nettype wire

// [test/operating_mode_select_tb.sv]
/* operating_mode_select_tb: straps, mode writes, debug, bus traffic.
   assumes: oms_bus_model answers reads; clock enable held high. */
`default_nettype none
module operating_mode_select_tb;
    import oms_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic bg, mb, ma, wr, den, dact, req, rwe, rwd, mv, de, dac, bsy, dn;
    logic dex, b1;   // debug exit command, busy seen in first cycle
    oms_mode_t  wd, mode;
    oms_flags_t fl;
    logic [15:0] ra, rw, rd;
    logic [7:0]  ga, gd, pai, pbi, pa, pao, pb, pbo;
    logic [15:0] pv [8];   // port outputs per cycle
    logic [15:0] ov [8];   // port enables per cycle
    int fail_count = 0;
    int check_count = 0;
    int n;
    oms_mode_ctrl dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
        .background_pin_i(bg), .mode_pin_b_i(mb), .mode_pin_a_i(ma),
        .mode_wr_i(wr), .mode_wr_data_i(wd), .dbg_enable_i(den),
        .dbg_activate_i(dact), .dbg_exit_i(dex), .req_i(req),
        .req_we_i(rwe), .req_word_i(rwd), .req_addr_i(ra),
        .req_wdata_i(rw), .gpio_a_i(ga), .gpio_a_dir_i(gd),
        .gpio_b_i(ga), .gpio_b_dir_i(gd), .port_a_i(pai), .port_b_i(pbi),
        .mode_valid_o(mv), .mode_o(mode), .flags_o(fl), .dbg_en_o(de),
        .dbg_act_o(dac), .busy_o(bsy), .done_o(dn), .rdata_o(rd),
        .port_a_o(pa), .port_a_oe_o(pao), .port_b_o(pb), .port_b_oe_o(pbo));
    oms_bus_model mem_u (.a_i(pa), .a_oe_i(pao), .b_i(pb), .b_oe_i(pbo),
        .clk_i(clk_i), .a_o(pai), .b_o(pbi));
    always #4 clk_i = ~clk_i;
    function automatic logic [7:0] f(input logic [15:0] x);
        return x[7:0] ^ 8'h3c;
    endfunction
    task automatic chk(input bit ok, input string m);
        check_count++;
        if (!ok) begin
            fail_count++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // reset with straps p, return after the capture edge
    task automatic boot(input logic [2:0] p);
        {bg, mb, ma} = p;
        rst_i = 1'b1;
        repeat (16) @(negedge clk_i);
        rst_i = 1'b0;
        @(negedge clk_i);
    endtask
    task automatic mw(input logic [2:0] v);
        wr = 1'b1;
        wd = v;
        @(negedge clk_i);
        wr = 1'b0;
        @(negedge clk_i);
    endtask
    // one transfer; records ports per cycle, done due in cycle e
    task automatic xfer(input logic w, d, input logic [15:0] a, v,
                        input int e);
        {req, rwe, rwd, ra, rw} = {1'b1, w, d, a, v};
        @(negedge clk_i);
        req = 1'b0;
        for (n = 1; !dn && n < 8; n++) begin
            if (n == 1)
                b1 = bsy;
            pv[n] = {pa, pb};
            ov[n] = {pao, pbo};
            @(negedge clk_i);
        end
        if (n == 8) begin
            chk(1'b0, "transfer timeout");
            test_done();
        end
        chk(dn === 1'b1 && !bsy && b1 && n == e, "done timing");
    endtask
    task automatic t_straps;
        logic [2:0] e;
        for (int i = 0; i < 8; i++) begin
            boot(i[2:0]);
            e = (i == 6) ? 3'h2 : i[2:0];
            chk(mv === 1'b1 && mode === e, "strap mode");
            chk(fl === {e[1:0] == 0, e[0], e[1:0] == 3, e[1:0] == 1, !e[2],
                e[1:0] == 2}, "flags");
            chk({de, dac} === {2{e == 0}}, "debug at start");
            if (e[1:0] == 0)
                chk(pa === ga && pao === gd, "gpio");
            if (e == 2)
                chk({pao, pbo} === 16'h0, "periph ports");
        end
        $display("strap test done");
    endtask
    task automatic t_bus;
        boot(3'h7);
        xfer(1, 1, 16'h12fe, 16'hbeef, 3);
        chk(pv[1] === 16'h12fe && ov[2] === 16'hffff, "wide addr");
        chk(pv[2] === 16'hbeef, "wide data");
        xfer(0, 1, 16'h12fe, 16'h0, 3);
        chk(rd === {f(16'h12fe), f(16'h12ff)}, "wide read");
        boot(3'h5);
        xfer(1, 1, 16'h40ff, 16'hc3a5, 5);
        chk(pv[2][15:8] === 8'hc3 && pv[4][15:8] === 8'ha5,
            "order");
        chk(pv[3] === 16'h4100, "second addr");
        xfer(0, 1, 16'h40ff, 16'h0, 5);
        chk(rd === {f(16'h40ff), f(16'h4100)}, "word read");
        xfer(0, 0, 16'h0203, 16'h0, 3);
        chk(rd === {8'h00, f(16'h0203)}, "byte read");
        $display("bus test done");
    endtask
    task automatic t_modes;
        boot(3'h4);
        mw(3'h3);
        chk(mode === 3'h7, "normal first write");
        mw(3'h5);
        chk(mode === 3'h7, "normal second write");
        boot(3'h0);
        mw(3'h3);
        chk(mode === 3'h0, "special first write");
        mw(3'h3);
        chk(mode === 3'h3, "special write");
        mw(3'h2);
        chk(mode === 3'h3, "periph select");
        mw(3'h7);
        chk(mode === 3'h7 && !fl.special, "leave special");
        boot(3'h2); // no debug commands while peripheral
        mw(3'h0);
        mw(3'h3);
        chk(mode === 3'h2, "periph locked");
        $display("mode test done");
    endtask
    task automatic t_debug;
        boot(3'h4);
        dact = 1'b1;
        mw(3'h4);
        dact = 1'b0;
        chk(dac === 1'b0, "activate unarmed");
        den = 1'b1;
        @(negedge clk_i);
        {den, dact} = 2'b01;
        @(negedge clk_i);
        dex = 1'b1;
        chk(de === 1'b1 && dac === 1'b1, "debug active");
        @(negedge clk_i);
        dact = 1'b0;
        chk(dac === 1'b1, "activate beats exit");
        @(negedge clk_i);
        dex = 1'b0;
        chk(dac === 1'b0 && de === 1'b1, "debug exit");
        $display("debug test done");
    endtask
    initial begin
        {bg, mb, ma, wr, den, dact, dex, req, rwe, rwd} = '0;
        {wd, ra, rw} = '0;
        ga = 8'ha5;
        gd = 8'h3c;
        t_straps();
        t_bus();
        t_modes();
        t_debug();
        test_done();
    end
endmodule
`default_nettype wire
